/* rtl/nvsrc_params.svh */
// Timing counts, sequence addresses and widths for the nv store/recall host controller.
`ifndef NVSRC_PARAMS_SVH
`define NVSRC_PARAMS_SVH
`define NVSRC_CLK_NS 25
`define NVSRC_DRAIN_NS 1000
`define NVSRC_BUSY_NS 300
`define NVSRC_RELEASE_NS 700
`define NVSRC_RESTORE_US 550
`define NVSRC_SAVE_MS 10
`define NVSRC_RECALL_US 20
`define NVSRC_CYC_MIN(ns) (((ns) + `NVSRC_CLK_NS - 1) / `NVSRC_CLK_NS)
`define NVSRC_CYC_MAX(ns) ((ns) / `NVSRC_CLK_NS)
`define NVSRC_DRAIN_CYC `NVSRC_CYC_MIN(`NVSRC_DRAIN_NS)
`define NVSRC_BUSY_CYC `NVSRC_CYC_MAX(`NVSRC_BUSY_NS)
`define NVSRC_RELEASE_CYC `NVSRC_CYC_MIN(`NVSRC_RELEASE_NS)
`define NVSRC_RESTORE_CYC `NVSRC_CYC_MIN(`NVSRC_RESTORE_US * 1000)
`define NVSRC_SAVE_CYC `NVSRC_CYC_MIN(`NVSRC_SAVE_MS * 1000000)
`define NVSRC_RECALL_CYC `NVSRC_CYC_MIN(`NVSRC_RECALL_US * 1000)
`define NVSRC_ACC_CYC 2
`define NVSRC_SEQ0 14'h0e38
`define NVSRC_SEQ1 14'h31c7
`define NVSRC_SEQ2 14'h03e0
`define NVSRC_SEQ3 14'h3c1f
`define NVSRC_SEQ4 14'h303f
`define NVSRC_SEQ_SAVE 14'h0fc0
`define NVSRC_SEQ_RECALL 14'h0c63
`define NVSRC_SEQ_BITS 14
`endif

/* rtl/nvsrc_pkg.sv */
// Types for the nv store/recall host controller.
package nvsrc_pkg;
  typedef enum logic [2:0] {
    NVSRC_CMD_READ,
    NVSRC_CMD_WRITE,
    NVSRC_CMD_SAVE_PIN,
    NVSRC_CMD_SAVE_SOFT,
    NVSRC_CMD_RECALL_SOFT
  } nvsrc_cmd_t;

  typedef struct packed {
    logic sel_n;
    logic wr_n;
    logic oe_n;
    logic [14:0] addr;
  } nvsrc_bus_t;

  typedef struct packed {
    nvsrc_cmd_t cmd;
    logic [14:0] addr;
    logic [7:0] wdata;
  } nvsrc_req_t;
endpackage : nvsrc_pkg

/* rtl/nvsrc_host.sv */
// Host controller that drives the nv static RAM pins for access, store and recall.
`timescale 1ns/1ps
`include "nvsrc_params.svh"
module nvsrc_host (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic reset,
  // User request side.
  input wire logic req_valid,
  input wire nvsrc_pkg::nvsrc_req_t req,
  output logic req_ready,
  output logic done,
  output logic [7:0] rdata,
  // Device pins.
  output nvsrc_pkg::nvsrc_bus_t bus,
  output logic [7:0] dq_out,
  output logic dq_oe_n,
  input wire logic [7:0] dq_in,
  output logic hw_save_busy_n_out,
  output logic hw_save_busy_n_oe_n,
  input wire logic hw_save_busy_n_in,
  // Power status.
  input wire logic supply_ok,
  output logic power_recall_busy,
  output logic written_q
);
  // ****************************************************************
  // Sequencer state.
  // ****************************************************************
  typedef enum logic [3:0] {
    ST_POWER, ST_IDLE, ST_ACC_LO, ST_ACC_HI, ST_SEQ_LO, ST_SEQ_HI,
    ST_SAVE_LOW, ST_SAVE_WAIT, ST_RELEASE, ST_BUSY
  } nvsrc_st_t;

  nvsrc_st_t st_q;
  nvsrc_pkg::nvsrc_req_t req_q;
  logic [31:0] cnt_q;
  logic [2:0] step_q;
  logic supply_q;

  function automatic logic [13:0] seq_addr(input logic [2:0] step, input logic recall);
    logic [13:0] a;
    a = 14'h0000;
    unique case (step)
      3'h0: a = `NVSRC_SEQ0;
      3'h1: a = `NVSRC_SEQ1;
      3'h2: a = `NVSRC_SEQ2;
      3'h3: a = `NVSRC_SEQ3;
      3'h4: a = `NVSRC_SEQ4;
      default: a = recall ? `NVSRC_SEQ_RECALL : `NVSRC_SEQ_SAVE;
    endcase
    return a;
  endfunction : seq_addr

  wire is_recall = (req_q.cmd == nvsrc_pkg::NVSRC_CMD_RECALL_SOFT);
  wire is_write = (req_q.cmd == nvsrc_pkg::NVSRC_CMD_WRITE);
  wire take = (st_q == ST_IDLE) && req_valid && hw_save_busy_n_in;
  wire cnt_end = (cnt_q == 32'h0);
  wire supply_fall = supply_q && !supply_ok;
  wire supply_rise = !supply_q && supply_ok;
  wire [14:0] seq_bus_addr = {1'b0, seq_addr(step_q, is_recall)};
  wire [31:0] soft_wait = is_recall ? 32'(`NVSRC_RECALL_CYC) : 32'(`NVSRC_SAVE_CYC);

  // ****************************************************************
  // State and timers.
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    supply_q <= supply_ok;
    if (reset) begin
      st_q <= ST_POWER;
      cnt_q <= 32'(`NVSRC_RESTORE_CYC);
      step_q <= 3'h0;
      req_q <= '0;
    end else if (supply_rise) begin
      st_q <= ST_POWER;
      cnt_q <= 32'(`NVSRC_RESTORE_CYC);
    end else if (!supply_ok) begin
      st_q <= ST_POWER;
      cnt_q <= 32'(`NVSRC_RESTORE_CYC);
    end else begin
      if (!cnt_end) begin
        cnt_q <= cnt_q - 32'h1;
      end
      unique case (st_q)
        ST_POWER: begin
          if (cnt_end) begin
            st_q <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          if (take) begin
            req_q <= req;
            step_q <= 3'h0;
            cnt_q <= 32'(`NVSRC_ACC_CYC);
            unique case (req.cmd)
              nvsrc_pkg::NVSRC_CMD_SAVE_PIN: begin
                st_q <= ST_SAVE_LOW;
                cnt_q <= 32'(`NVSRC_DRAIN_CYC);
              end
              nvsrc_pkg::NVSRC_CMD_SAVE_SOFT, nvsrc_pkg::NVSRC_CMD_RECALL_SOFT: begin
                st_q <= ST_SEQ_LO;
              end
              default: st_q <= ST_ACC_LO;
            endcase
          end
        end
        ST_ACC_LO: begin
          if (cnt_end) begin
            st_q <= ST_ACC_HI;
          end
        end
        ST_ACC_HI: st_q <= ST_IDLE;
        ST_SEQ_LO: begin
          if (cnt_end) begin
            st_q <= ST_SEQ_HI;
          end
        end
        ST_SEQ_HI: begin
          if (step_q == 3'h5) begin
            st_q <= ST_BUSY;
            cnt_q <= soft_wait;
          end else begin
            step_q <= step_q + 3'h1;
            st_q <= ST_SEQ_LO;
            cnt_q <= 32'(`NVSRC_ACC_CYC);
          end
        end
        ST_SAVE_LOW: begin
          if (cnt_end) begin
            st_q <= ST_SAVE_WAIT;
            cnt_q <= 32'(`NVSRC_SAVE_CYC);
          end
        end
        ST_SAVE_WAIT: begin
          if (cnt_end) begin
            st_q <= ST_RELEASE;
            cnt_q <= 32'(`NVSRC_RELEASE_CYC);
          end
        end
        ST_RELEASE, ST_BUSY: begin
          if (cnt_end) begin
            st_q <= ST_IDLE;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Pins and user outputs.
  // ****************************************************************
  wire acc_lo = (st_q == ST_ACC_LO);
  wire seq_lo = (st_q == ST_SEQ_LO);
  wire pin_low = (st_q == ST_SAVE_LOW) || (st_q == ST_SAVE_WAIT);
  wire done_d = (st_q == ST_ACC_HI) ||
                ((st_q == ST_RELEASE || st_q == ST_BUSY) && cnt_end && supply_ok);

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      bus <= '{sel_n: 1'b1, wr_n: 1'b1, oe_n: 1'b1, addr: 15'h0000};
      dq_out <= 8'h00;
      dq_oe_n <= 1'b1;
      hw_save_busy_n_out <= 1'b1;
      hw_save_busy_n_oe_n <= 1'b1;
      req_ready <= 1'b0;
      done <= 1'b0;
      rdata <= 8'h00;
      power_recall_busy <= 1'b1;
      written_q <= 1'b0;
    end else begin
      bus.sel_n <= !(acc_lo || seq_lo);
      bus.wr_n <= !(acc_lo && is_write);
      bus.oe_n <= !(acc_lo && !is_write);
      bus.addr <= seq_lo ? seq_bus_addr : req_q.addr;
      dq_out <= req_q.wdata;
      dq_oe_n <= !(acc_lo && is_write) || pin_low;
      hw_save_busy_n_out <= 1'b0;
      hw_save_busy_n_oe_n <= !pin_low;
      req_ready <= (st_q == ST_IDLE) && !take && supply_ok && hw_save_busy_n_in;
      done <= done_d;
      if (acc_lo && !is_write && cnt_end) begin
        rdata <= dq_in;
      end
      power_recall_busy <= (st_q == ST_POWER);
      if (acc_lo && is_write) begin
        written_q <= 1'b1;
      end else if ((st_q == ST_BUSY || st_q == ST_SAVE_WAIT || st_q == ST_POWER) && cnt_end) begin
        written_q <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Checks.
  // ****************************************************************
  seq_order_a: assert property (@(posedge ref_clk) disable iff (reset)
    (st_q == ST_SEQ_HI && step_q != 3'h5) |=> step_q == $past(step_q) + 3'h1)
    else $error("sequence step skipped");
  seq_wr_a: assert property (@(posedge ref_clk) disable iff (reset)
    $past(seq_lo) |-> bus.wr_n)
    else $error("write strobe low in sequence");
  seq_msb_a: assert property (@(posedge ref_clk) disable iff (reset)
    $past(seq_lo) |-> !bus.addr[14])
    else $error("sequence address top bit set");
  pin_float_a: assert property (@(posedge ref_clk) disable iff (reset)
    !hw_save_busy_n_oe_n |-> dq_oe_n && bus.sel_n)
    else $error("bus driven during pin store");
  drain_a: assert property (@(posedge ref_clk) disable iff (reset)
    $rose(st_q == ST_SAVE_LOW) |-> (st_q == ST_SAVE_LOW) [*8])
    else $error("drain wait too short");
  release_a: assert property (@(posedge ref_clk) disable iff (reset || !supply_ok)
    $rose(st_q == ST_RELEASE) |-> ##[1:30] st_q == ST_IDLE)
    else $error("inhibit release too slow");
  busy_ready_a: assert property (@(posedge ref_clk) disable iff (reset)
    (st_q == ST_BUSY) |=> !req_ready)
    else $error("ready during nv cycle");
  write_flag_a: assert property (@(posedge ref_clk) disable iff (reset)
    (acc_lo && is_write) |=> written_q)
    else $error("write flag not set");
  seq_sel_a: assert property (@(posedge ref_clk) disable iff (reset)
    (st_q == ST_SEQ_HI) |-> !bus.sel_n ##1 bus.sel_n)
    else $error("select edge missing in sequence");
  cov_soft_save_c: cover property (@(posedge ref_clk) st_q == ST_BUSY && !is_recall);
  cov_soft_recall_c: cover property (@(posedge ref_clk) st_q == ST_BUSY && is_recall);
  cov_pin_save_c: cover property (@(posedge ref_clk) st_q == ST_SAVE_WAIT);
  cov_write_c: cover property (@(posedge ref_clk) done && is_write);
endmodule : nvsrc_host

/* bench/nvsrc_dev_model.sv */
// Behavioural model of the nv static RAM seen by the host controller.
`timescale 1ns/1ps
`include "nvsrc_params.svh"
module nvsrc_dev_model #(
  parameter int SAVE_NS = 2000,
  parameter int POWUP_NS = 400000
) (
  // Device pins.
  input wire nvsrc_pkg::nvsrc_bus_t bus,
  input wire logic [7:0] dq_host,
  input wire logic pin_host_oe_n,
  input wire logic supply_ok,
  output logic [7:0] dq_dev,
  output logic pin_n
);
  logic [7:0] sram [0:32767];
  logic [7:0] nvm [0:32767];
  logic [13:0] seq_a [0:4];
  logic wrote = 1'b0;
  logic busy = 1'b0;
  logic auto_low = 1'b0;
  logic flip = 1'b0;
  logic save_low = 1'b0;
  int step = 0;
  assign pin_n = pin_host_oe_n && !auto_low && !save_low;
  wire rd_en = !bus.sel_n && !bus.oe_n && bus.wr_n && pin_n && !busy;
  wire wr_act = !bus.sel_n && !bus.wr_n && pin_n && !busy;
  assign dq_dev = rd_en ? sram[bus.addr] : {4{flip, ~flip}};
  always #10 flip = ~flip;
  task automatic copy(input bit to_nv);
    for (int i = 0; i < 32768; i++) begin
      if (to_nv) nvm[i] = sram[i];
      else sram[i] = nvm[i];
    end
    wrote = 1'b0;
  endtask : copy
  initial begin
    seq_a = '{`NVSRC_SEQ0, `NVSRC_SEQ1, `NVSRC_SEQ2, `NVSRC_SEQ3, `NVSRC_SEQ4};
    for (int i = 0; i < 32768; i++) nvm[i] = 8'(i) ^ 8'h3c;
  end
  always @(negedge wr_act) begin
    sram[bus.addr] = dq_host;
    wrote = 1'b1;
  end
  always @(negedge bus.sel_n) begin
    #1;
    if (!bus.wr_n || busy || !pin_n) begin
      step = 0;
    end else if (step == 5 && bus.addr[13:0] == `NVSRC_SEQ_SAVE) begin
      step = 0;
      busy = 1'b1;
      #(SAVE_NS) copy(1'b1);
      busy = 1'b0;
    end else if (step == 5 && bus.addr[13:0] == `NVSRC_SEQ_RECALL) begin
      step = 0;
      busy = 1'b1;
      #(`NVSRC_RECALL_US * 500) copy(1'b0);
      busy = 1'b0;
    end else if (step < 5 && bus.addr[13:0] == seq_a[step]) begin
      step = step + 1;
    end else begin
      step = (bus.addr[13:0] == seq_a[0]) ? 1 : 0;
    end
  end
  always @(negedge pin_host_oe_n) begin
    #(`NVSRC_BUSY_NS / 2) save_low = 1'b1;
    #(`NVSRC_DRAIN_NS) busy = 1'b1;
    if (wrote) #(SAVE_NS) copy(1'b1);
    save_low = 1'b0;
    wait (pin_host_oe_n);
    #(`NVSRC_RELEASE_NS / 2) busy = 1'b0;
  end
  always @(negedge supply_ok) begin
    auto_low = 1'b1;
    #1000 auto_low = 1'b0;
    if (wrote) copy(1'b1);
  end
  always @(posedge supply_ok) begin
    busy = 1'b1;
    #(POWUP_NS) copy(1'b0);
    busy = 1'b0;
  end
endmodule : nvsrc_dev_model

/* bench/nvsrc_host_bench.sv */
// Self-checking bench for the nv store/recall host controller.
`timescale 1ns/1ps
module nvsrc_host_bench;
  typedef struct packed {
    nvsrc_pkg::nvsrc_cmd_t cmd;
    logic [14:0] addr;
    logic [7:0] wdata;
    logic [7:0] exp_rd;
  } nvsrc_row_t;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic req_valid = 1'b0;
  nvsrc_pkg::nvsrc_req_t req = '0;
  logic supply_ok = 1'b0;
  logic req_ready, done, power_recall_busy, written_q, dq_oe_n, pin_oe_n, pin_n, pin_out;
  logic [7:0] rdata, dq_out, dq_dev, rd;
  nvsrc_pkg::nvsrc_bus_t bus;
  int error_cnt = 0;
  int comparisons = 0;
  nvsrc_row_t rows [8] = '{
    '{nvsrc_pkg::NVSRC_CMD_WRITE, 15'h0010, 8'ha5, 8'h00},
    '{nvsrc_pkg::NVSRC_CMD_WRITE, 15'h4010, 8'h3c, 8'h00},
    '{nvsrc_pkg::NVSRC_CMD_READ, 15'h0010, 8'h00, 8'ha5},
    '{nvsrc_pkg::NVSRC_CMD_READ, 15'h4010, 8'h00, 8'h3c},
    '{nvsrc_pkg::NVSRC_CMD_READ, 15'h0001, 8'h00, 8'h3d},
    '{nvsrc_pkg::NVSRC_CMD_WRITE, 15'h7fff, 8'h5a, 8'h00},
    '{nvsrc_pkg::NVSRC_CMD_READ, 15'h7fff, 8'h00, 8'h5a},
    '{nvsrc_pkg::NVSRC_CMD_READ, 15'h0000, 8'h00, 8'h3c}};
  always #12.5 ref_clk = ~ref_clk;
  nvsrc_host nvsrc_host_inst (.ref_clk(ref_clk), .reset(reset), .req_valid(req_valid),
    .req(req), .req_ready(req_ready), .done(done), .rdata(rdata), .bus(bus),
    .dq_out(dq_out), .dq_oe_n(dq_oe_n), .dq_in(dq_dev), .hw_save_busy_n_out(pin_out),
    .hw_save_busy_n_oe_n(pin_oe_n), .hw_save_busy_n_in(pin_n), .supply_ok(supply_ok),
    .power_recall_busy(power_recall_busy), .written_q(written_q));
  nvsrc_dev_model nvsrc_dev_model_inst (.bus(bus), .dq_host(dq_out),
    .pin_host_oe_n(pin_oe_n), .supply_ok(supply_ok), .dq_dev(dq_dev), .pin_n(pin_n));
  task automatic print_verdict();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wait_for(input int lim, input bit on_done);
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      #1;
      n++;
    end while (((on_done ? done : req_ready) !== 1'b1) && n < lim);
    if ((on_done ? done : req_ready) !== 1'b1) begin
      error_cnt++;
      $display("[ERR] %0t wait ran out", $time);
      print_verdict();
    end
  endtask : wait_for
  task automatic issue(input nvsrc_pkg::nvsrc_cmd_t cmd, input logic [14:0] a,
                       input logic [7:0] d);
    wait_for(30000, 1'b0);
    @(posedge ref_clk);
    req_valid <= 1'b1;
    req <= '{cmd, a, d};
    @(posedge ref_clk);
    req_valid <= 1'b0;
  endtask : issue
  task automatic do_op(input nvsrc_pkg::nvsrc_cmd_t cmd, input logic [14:0] a,
                       input logic [7:0] d, input int lim);
    issue(cmd, a, d);
    wait_for(lim, 1'b1);
    rd = rdata;
  endtask : do_op
  initial begin
    @(posedge ref_clk);
    supply_ok <= 1'b1;
    repeat (5) @(posedge ref_clk);
    reset <= 1'b0;
    #1;
    chk(power_recall_busy, 8'h01);
    chk(req_ready, 8'h00);
    foreach (rows[i]) begin
      do_op(rows[i].cmd, rows[i].addr, rows[i].wdata, 50);
      if (rows[i].cmd == nvsrc_pkg::NVSRC_CMD_READ) chk(rd, rows[i].exp_rd);
    end
    chk(written_q, 8'h01);
    do_op(nvsrc_pkg::NVSRC_CMD_RECALL_SOFT, 15'h0000, 8'h00, 2000);
    chk(written_q, 8'h00);
    do_op(nvsrc_pkg::NVSRC_CMD_READ, 15'h0010, 8'h00, 50);
    chk(rd, 8'h2c);
    do_op(nvsrc_pkg::NVSRC_CMD_WRITE, 15'h0010, 8'h77, 50);
    @(posedge ref_clk);
    supply_ok <= 1'b0;
    repeat (100) @(posedge ref_clk);
    #1;
    chk(req_ready, 8'h00);
    chk(power_recall_busy, 8'h01);
    @(posedge ref_clk);
    supply_ok <= 1'b1;
    do_op(nvsrc_pkg::NVSRC_CMD_READ, 15'h0010, 8'h00, 50);
    chk(rd, 8'h77);
    do_op(nvsrc_pkg::NVSRC_CMD_WRITE, 15'h0020, 8'h11, 50);
    issue(nvsrc_pkg::NVSRC_CMD_SAVE_SOFT, 15'h0000, 8'h00);
    repeat (150) @(posedge ref_clk);
    #1;
    chk(req_ready, 8'h00);
    chk(bus.sel_n, 8'h01);
    @(posedge ref_clk);
    reset <= 1'b1;
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    #1;
    chk(power_recall_busy, 8'h01);
    chk(req_ready, 8'h00);
    chk(pin_oe_n, 8'h01);
    @(posedge ref_clk);
    #1;
    chk(power_recall_busy, 8'h01);
    chk(bus.sel_n, 8'h01);
    do_op(nvsrc_pkg::NVSRC_CMD_WRITE, 15'h0020, 8'h22, 50);
    do_op(nvsrc_pkg::NVSRC_CMD_RECALL_SOFT, 15'h0000, 8'h00, 2000);
    do_op(nvsrc_pkg::NVSRC_CMD_READ, 15'h0020, 8'h00, 50);
    chk(rd, 8'h11);
    do_op(nvsrc_pkg::NVSRC_CMD_WRITE, 15'h0030, 8'h44, 50);
    issue(nvsrc_pkg::NVSRC_CMD_SAVE_PIN, 15'h0000, 8'h00);
    repeat (60) @(posedge ref_clk);
    #1;
    chk(pin_oe_n, 8'h00);
    chk(pin_out, 8'h00);
    chk(pin_n, 8'h00);
    chk(dq_oe_n, 8'h01);
    chk(bus.sel_n, 8'h01);
    chk(req_ready, 8'h00);
    print_verdict();
  end
endmodule : nvsrc_host_bench
